/* design/tc_readout_consts.vh */
// Constants for the thermocouple serial readout controller
`ifndef TC_READOUT_CONSTS_VH
`define TC_READOUT_CONSTS_VH

// System clock period in ns
`define CLK_PERIOD_NS 10

// Conversion period, typical and longest, in ms
`define CONV_PERIOD_TYP_MS 70
`define CONV_PERIOD_MAX_MS 100

// Cycles for one full conversion period (typical)
`define CONV_PERIOD_CYC (`CONV_PERIOD_TYP_MS * 1000000 / `CLK_PERIOD_NS)
// Longest period in cycles, rounded down
`define CONV_MAX_CYC (`CONV_PERIOD_MAX_MS * 1000000 / `CLK_PERIOD_NS)
// Cycles for each of the three phases
`define PHASE_CYC (`CONV_PERIOD_CYC / 3)

// Switch settling time before an ADC start, in ns
`define SETTLE_NS 2000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Output word field positions
`define WORD_W 32
`define TC_MSB 31
`define TC_LSB 18
`define RSV_HI 17
`define FAULT_BIT 16
`define CJ_MSB 15
`define CJ_LSB 4
`define RSV_LO 3
`define SCV_BIT 2
`define SCG_BIT 1
`define OC_BIT 0

// Field widths
`define TC_W 14
`define CJ_W 12

// Open thermocouple report: sign 0, magnitude all ones
`define TC_OPEN_CODE 14'h1FFF

// Reset values
`define TC_RESET 14'h0000
`define CJ_RESET 12'h000
`define WORD_RESET 32'h00000000

// Synchroniser lane positions
`define SY_CS 0
`define SY_SCK 1
`define SY_SCV 2
`define SY_SCG 3
`define SY_OC 4
`define SY_W 5

`endif

/* design/pin_sync.v */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // pin_sync

/* design/thermocouple_serial_readout.v */
// Thermocouple converter controller: phase sequencer, compensation, serial read port
//
// Functional notes
// - Serial port is enabled only while chip select is low; clock ignored otherwise.
// - Every conversion period runs cold-junction, thermocouple and fault phases.
// - Conversions run continuously without host command, also during reads.
// - Output word loads only while chip select is high; frozen while low.
// - Chip select fall puts sign bit 31 on data out at once.
// - Bits 30 to 18 follow MSB first, one per serial clock fall.
// - Reference-junction field follows the fault bit, starting at bit 15.
// - Early chip select rise stops shifting and reopens result updates.
// - Open inputs report sign zero and all thirteen magnitude bits one.
// - Bit 2 short to supply, bit 1 short to ground, bit 0 open.
// - Bit 16 is one whenever any individual fault is present.
// - Cold phase: thermo switch open, cold closed, ground closed, fault open.
// - Thermo phase: fault and cold open, ground and thermo switch closed.
// - Fault phase: thermo, cold and ground open; both fault switches closed.
// - Reported temperature is uncompensated thermocouple plus die temperature.
// - One linear gain from voltage to temperature, no nonlinearity correction.
// - Thermocouple value uses 14-bit resolution filling the signed field.
// - Bits 31..18 signed thermocouple temperature, quarter degree steps.
// - Bits 15..4 signed reference temperature, sixteenth degree steps.
// - Reserved bits 17 and 3 always shift out zero.
// - One full three-phase period completes within 100 ms.
`timescale 1ns/1ps
`include "tc_readout_consts.vh"

module thermocouple_serial_readout #(
  parameter PHASE_CYCLES = `PHASE_CYC,
  parameter SETTLE_CYCLES = `SETTLE_CYC,
  parameter TC_GAIN_NUM = 1,
  parameter TC_GAIN_SHIFT = 0,
  parameter CNT_W = 24
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_cs_n,
  input wire i_sck,
  input wire i_short_vcc,
  input wire i_short_gnd,
  input wire i_open_tc,
  input wire i_adc_done,
  input wire [13:0] i_adc_data,
  output reg o_adc_start,
  output reg o_adc_sel_tc,
  output reg o_fault_switch_a,
  output reg o_fault_switch_b,
  output reg o_neg_ground_switch,
  output reg o_thermo_to_adc_switch,
  output reg o_cold_junction_switch,
  output reg o_sdo,
  output reg o_sdo_oe,
  output reg o_phase_end,
  output reg o_result_valid
);

  // Phase states, one-hot
  localparam [2:0] ST_CJ = 3'b001;
  localparam [2:0] ST_TC = 3'b010;
  localparam [2:0] ST_FLT = 3'b100;

  // Counter limits, cut to the counter width on purpose; CNT_W must hold PHASE_CYCLES - 1
  localparam integer PHASE_LAST_I = PHASE_CYCLES - 1;
  localparam integer SETTLE_LAST_I = SETTLE_CYCLES;
  localparam [CNT_W-1:0] PHASE_LAST = PHASE_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[CNT_W-1:0];
  localparam [5:0] BITS_LAST = 6'h20;

  // Saturation limits of the signed 14-bit temperature field
  localparam [13:0] TC_POS_MAX = 14'h1FFF;
  localparam [13:0] TC_NEG_MIN = 14'h2000;

  // Saturating signed add of two 14-bit quarter-degree values
  function [13:0] sat_add14;
    input [13:0] a;
    input [13:0] b;
    reg [14:0] s;
    begin
      s = {a[13], a} + {b[13], b};
      // Saturate rather than wrap, so a far reading never flips sign
      if (s[14] != s[13])
        sat_add14 = s[14] ? TC_NEG_MIN : TC_POS_MAX;
      else
        sat_add14 = s[13:0];
    end
  endfunction

  // Synchronised pins
  wire [`SY_W-1:0] pins_sync;
  wire cs_n_s;
  wire sck_s;
  wire scv_s;
  wire scg_s;
  wire oc_s;

  // Select, serial clock and fault pins reach the logic only through this two-flop stage
  // Chip select idles high so the port starts deselected
  pin_sync #(
    .WIDTH(`SY_W),
    .RESET_VAL(5'h01)
  ) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_async({i_open_tc, i_short_gnd, i_short_vcc, i_sck, i_cs_n}),
    .o_sync(pins_sync)
  );

  assign cs_n_s = pins_sync[`SY_CS];
  assign sck_s = pins_sync[`SY_SCK];
  assign scv_s = pins_sync[`SY_SCV];
  assign scg_s = pins_sync[`SY_SCG];
  assign oc_s = pins_sync[`SY_OC];

  // Conversion sequencer: three phases in a fixed loop
  // It never waits on the host, so a slow read cannot stall a measurement
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CNT_W-1:0] phase_cnt;
  reg adc_busy;
  reg first_pass_done;
  reg [13:0] tc_raw;
  reg [11:0] cj_temp;
  reg [2:0] fault_flags;
  wire phase_tick;

  // Phase divider gives a one-cycle enable at the end of each phase
  assign phase_tick = (phase_cnt == PHASE_LAST);

  // Next phase; the loop never waits on the host
  // The fault phase hands back to the cold phase, so the loop repeats
  always @* begin
    case (state)
      ST_CJ: next_state = phase_tick ? ST_TC : ST_CJ;
      ST_TC: next_state = phase_tick ? ST_FLT : ST_TC;
      ST_FLT: next_state = phase_tick ? ST_CJ : ST_FLT;
      default: next_state = ST_CJ;
    endcase
  end

  // State register and phase counter; bounded, so one period fits 100 ms
  // o_phase_end marks each boundary one cycle after the last phase cycle
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_CJ;
      phase_cnt <= {CNT_W{1'b0}};
      o_phase_end <= 1'b0;
    end else begin
      state <= next_state;
      o_phase_end <= phase_tick;
      if (phase_tick)
        phase_cnt <= {CNT_W{1'b0}};
      else
        phase_cnt <= phase_cnt + 1'b1;
    end
  end

  // Switch drive per phase, registered from the next state
  // Using the next state moves the switches on the very edge that the phase changes
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fault_switch_a <= 1'b0;
      o_fault_switch_b <= 1'b0;
      o_neg_ground_switch <= 1'b1;
      o_thermo_to_adc_switch <= 1'b0;
      o_cold_junction_switch <= 1'b1;
    end else begin
      case (next_state)
        ST_CJ: begin
          o_thermo_to_adc_switch <= 1'b0;
          o_cold_junction_switch <= 1'b1;
          o_neg_ground_switch <= 1'b1;
          o_fault_switch_a <= 1'b0;
          o_fault_switch_b <= 1'b0;
        end
        ST_TC: begin
          o_fault_switch_a <= 1'b0;
          o_fault_switch_b <= 1'b0;
          o_cold_junction_switch <= 1'b0;
          o_neg_ground_switch <= 1'b1;
          o_thermo_to_adc_switch <= 1'b1;
        end
        ST_FLT: begin
          o_thermo_to_adc_switch <= 1'b0;
          o_cold_junction_switch <= 1'b0;
          o_neg_ground_switch <= 1'b0;
          o_fault_switch_a <= 1'b1;
          o_fault_switch_b <= 1'b1;
        end
        default: begin
          o_thermo_to_adc_switch <= 1'b0;
          o_cold_junction_switch <= 1'b1;
          o_neg_ground_switch <= 1'b1;
          o_fault_switch_a <= 1'b0;
          o_fault_switch_b <= 1'b0;
        end
      endcase
    end
  end

  // ADC start after switches settle in the two measuring phases
  // sel_tc follows the phase, so it is steady long before the start pulse
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_adc_start <= 1'b0;
      o_adc_sel_tc <= 1'b0;
      adc_busy <= 1'b0;
    end else begin
      o_adc_start <= 1'b0;
      o_adc_sel_tc <= (state == ST_TC);
      if (phase_tick) begin
        adc_busy <= 1'b0;
      end else if (state != ST_FLT && phase_cnt == SETTLE_LAST) begin
        o_adc_start <= 1'b1;
        adc_busy <= 1'b1;
      end else if (adc_busy && i_adc_done) begin
        adc_busy <= 1'b0;
      end
    end
  end

  // Capture ADC results; a late result is dropped and the old value kept
  // The die reading keeps its top twelve bits, in sixteenths of a degree
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tc_raw <= `TC_RESET;
      cj_temp <= `CJ_RESET;
    end else if (adc_busy && i_adc_done && !phase_tick) begin
      if (state == ST_CJ)
        cj_temp <= i_adc_data[13:2];
      else if (state == ST_TC)
        tc_raw <= i_adc_data;
    end
  end

  // Fault comparators are sampled at the close of the fault phase
  // A fault that comes and goes inside one phase is never reported
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_flags <= 3'h0;
      first_pass_done <= 1'b0;
    end else if (state == ST_FLT && phase_tick) begin
      fault_flags <= {scv_s, scg_s, oc_s};
      first_pass_done <= 1'b1;
    end
  end

  // Compensation arithmetic
  // Pure combinational path from the latest results to the next output word
  wire signed [13:0] tc_raw_s;
  wire signed [31:0] tc_scaled_full;
  wire [13:0] tc_uncomp;
  wire [13:0] cj_quarter;
  wire [13:0] tc_comp;
  wire any_fault;
  wire [13:0] tc_field;
  wire [`WORD_W-1:0] word_next;

  assign tc_raw_s = tc_raw;
  // Single linear gain, no curve correction
  assign tc_scaled_full = (tc_raw_s * TC_GAIN_NUM) >>> TC_GAIN_SHIFT;
  assign tc_uncomp = tc_scaled_full[13:0];
  // Die temperature in sixteenths, brought to quarters with sign kept
  assign cj_quarter = {{4{cj_temp[11]}}, cj_temp[11:2]};
  assign tc_comp = sat_add14(tc_uncomp, cj_quarter);
  assign any_fault = |fault_flags;
  // Open inputs override the temperature field
  assign tc_field = fault_flags[0] ? `TC_OPEN_CODE : tc_comp;

  // Output word, most significant field first
  assign word_next = {tc_field,
                      1'b0,
                      any_fault,
                      cj_temp,
                      1'b0,
                      fault_flags};

  // Serial read port
  // Every pin edge is seen three system clocks late; the host timing allows for it
  reg cs_n_d;
  reg sck_d;
  reg [`WORD_W-1:0] out_word;
  reg [`WORD_W-1:0] shift;
  reg [5:0] bit_cnt;
  wire cs_fall;
  wire sck_fall;

  // Edge detection on the synchronised pins
  // Reset values equal the pin idle levels, so no false edge follows reset
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  assign cs_fall = cs_n_d && !cs_n_s;
  // Serial clock counts only while selected
  assign sck_fall = sck_d && !sck_s && !cs_n_s;

  // Result word tracks new results only while deselected
  // Freeze keys off the synchronised select, the same level the shifter sees
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      out_word <= `WORD_RESET;
      o_result_valid <= 1'b0;
    end else if (cs_n_s) begin
      out_word <= word_next;
      o_result_valid <= first_pass_done;
    end
  end

  // Shifter: load on select, advance on each serial clock fall
  // After the last bit the count stops and only zeros leave the port
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      shift <= `WORD_RESET;
      bit_cnt <= 6'h00;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (cs_n_s) begin
      bit_cnt <= 6'h00;
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (cs_fall) begin
      shift <= {out_word[`WORD_W-2:0], 1'b0};
      bit_cnt <= 6'h01;
      o_sdo <= out_word[`TC_MSB];
      o_sdo_oe <= 1'b1;
    end else if (sck_fall) begin
      shift <= {shift[`WORD_W-2:0], 1'b0};
      o_sdo <= shift[`WORD_W-1];
      if (bit_cnt != BITS_LAST)
        bit_cnt <= bit_cnt + 1'b1;
      else
        o_sdo <= 1'b0;
    end
  end

endmodule // thermocouple_serial_readout

/* verification/tc_readout_monitor.sv */
// Checker for switch phases, phase timing and the serial read port
`timescale 1ns/1ps
module tc_readout_monitor #(
  parameter PHASE_CYCLES = 200
) (
  input logic i_sys_clk,
  input logic i_resetn,
  input logic i_cs_n,
  input logic i_sck,
  input logic o_adc_start,
  input logic o_fault_switch_a,
  input logic o_fault_switch_b,
  input logic o_neg_ground_switch,
  input logic o_thermo_to_adc_switch,
  input logic o_cold_junction_switch,
  input logic o_sdo,
  input logic o_sdo_oe,
  input logic o_phase_end,
  input logic o_result_valid
);
  logic [15:0] gap;
  logic [3:0] fall_hist;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Cycles since the last phase end, and recent serial clock falls
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap <= 16'h0000;
      fall_hist <= 4'h0;
    end else begin
      gap <= o_phase_end ? 16'h0000 : gap + 16'h0001;
      fall_hist <= {fall_hist[2:0], $fell(i_sck)};
    end
  end
  // Select pin held low, or idle high, over four samples
  sequence s_cs_held;
    (!i_cs_n) [*4];
  endsequence
  sequence s_cs_idle;
    i_cs_n [*4];
  endsequence
  a_cold_switches: assert property (
    o_cold_junction_switch |-> o_neg_ground_switch && !o_thermo_to_adc_switch && !o_fault_switch_a && !o_fault_switch_b)
    else $error("cold phase switch mix");
  a_tc_switches: assert property (
    o_thermo_to_adc_switch |-> o_neg_ground_switch && !o_cold_junction_switch && !o_fault_switch_a && !o_fault_switch_b)
    else $error("thermocouple phase switch mix");
  a_fault_switches: assert property (
    o_fault_switch_a |-> o_fault_switch_b && !o_neg_ground_switch && !o_thermo_to_adc_switch && !o_cold_junction_switch)
    else $error("fault phase switch mix");
  a_phase_order: assert property (
    $rose(o_fault_switch_a) |-> $past(o_thermo_to_adc_switch) && !o_thermo_to_adc_switch)
    else $error("fault phase not after thermocouple phase");
  a_period_bound: assert property (gap < PHASE_CYCLES + 2)
    else $error("phase overran its length");
  a_start_pulse: assert property (
    o_adc_start |-> !o_fault_switch_a ##1 !o_adc_start)
    else $error("converter start misplaced");
  a_first_bit: assert property ($fell(i_cs_n) |-> ##[2:4] o_sdo_oe)
    else $error("data not driven after select fall");
  a_release_oe: assert property (s_cs_idle |-> !o_sdo_oe)
    else $error("data driven while deselected");
  a_data_steps: assert property (
    o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo) |-> |fall_hist)
    else $error("data moved without a clock fall");
  a_valid_frozen: assert property (s_cs_held |-> $stable(o_result_valid))
    else $error("results changed during a read");
endmodule // tc_readout_monitor
bind thermocouple_serial_readout tc_readout_monitor #(.PHASE_CYCLES(PHASE_CYCLES)) mon (.i_sys_clk(i_sys_clk),
  .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sck(i_sck), .o_adc_start(o_adc_start),
  .o_fault_switch_a(o_fault_switch_a), .o_fault_switch_b(o_fault_switch_b),
  .o_neg_ground_switch(o_neg_ground_switch), .o_thermo_to_adc_switch(o_thermo_to_adc_switch),
  .o_cold_junction_switch(o_cold_junction_switch), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
  .o_phase_end(o_phase_end), .o_result_valid(o_result_valid));

/* verification/tc_host_model.sv */
// Host serial master that reads the conversion word
`timescale 1ns/1ps
module tc_host_model (
  input logic i_clk,
  input logic i_sdo,
  input logic i_sdo_oe,
  output logic o_cs_n,
  output logic o_sck
);
  // Port idle, clock still outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
  end
  // Reads n bits on clock rises, 80 ns link period, after holding select low hold_cyc + 10 cycles
  task automatic read(input int n, input int hold_cyc, output logic [31:0] w);
    w = 32'h00000000;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (hold_cyc + 10) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_sck <= 1'b1;
      w = {w[30:0], i_sdo_oe ? i_sdo : 1'bx};
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
    o_cs_n <= 1'b1;
    repeat (20) @(posedge i_clk);
  endtask
endmodule // tc_host_model

/* verification/thermocouple_serial_readout_tb.sv */
// Testbench for the thermocouple serial readout controller
`timescale 1ns/1ps
module thermocouple_serial_readout_tb;
  localparam int PH = 200;
  logic clk, rst_n, cs_n, sck, scv, scg, oc, done, start, sel, fa, fb, ng, tsw, csw, sdo, oe, pend, valid;
  logic [13:0] data, tcu, t_old;
  logic [11:0] die;
  logic [31:0] w;
  int err_total = 0;
  int total_checks = 0;
  thermocouple_serial_readout #(.PHASE_CYCLES(PH), .SETTLE_CYCLES(4)) dut (.i_sys_clk(clk), .i_resetn(rst_n),
    .i_cs_n(cs_n), .i_sck(sck), .i_short_vcc(scv), .i_short_gnd(scg), .i_open_tc(oc), .i_adc_done(done),
    .i_adc_data(data), .o_adc_start(start), .o_adc_sel_tc(sel), .o_fault_switch_a(fa), .o_fault_switch_b(fb),
    .o_neg_ground_switch(ng), .o_thermo_to_adc_switch(tsw), .o_cold_junction_switch(csw), .o_sdo(sdo),
    .o_sdo_oe(oe), .o_phase_end(pend), .o_result_valid(valid));
  tc_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_cs_n(cs_n), .o_sck(sck));
  // Converter answers one cycle after each start
  always @(posedge clk) begin
    done <= start;
    data <= sel ? tcu : {die, 2'b00};
  end
  task automatic final_report;
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Word from raw thermocouple code, die code and fault flags
  function automatic logic [31:0] exp_word(input logic [13:0] t, input logic [11:0] c, input logic [2:0] f);
    logic [13:0] s;
    s = t + {{4{c[11]}}, c[11:2]};
    if (f[0])
      s = 14'h1FFF;
    return {s, 1'b0, |f, c, 1'b0, f};
  endfunction
  // Waits for four phase ends so one fresh full period has run
  task automatic wait_period;
    int n;
    n = 0;
    for (int k = 0; k < 8 * PH && n < 4; k++) begin
      @(posedge clk);
      if (pend === 1'b1)
        n++;
    end
    if (n < 4) begin
      err_total++;
      $display("MISMATCH %0t no phase progress", $time);
      final_report;
    end
  endtask
  task automatic t_full;
    wait_period;
    check({31'h0, valid}, 32'h1, "valid");
    check({31'h0, oe}, 32'h0, "idle drive");
    host.read(32, 0, w);
    check(w, exp_word(tcu, die, 3'h0), "full word");
  endtask
  task automatic t_short;
    tcu <= 14'h3E00;
    wait_period;
    host.read(14, 0, w);
    check(w, exp_word(14'h3E00, die, 3'h0) >> 18, "14 bit read");
  endtask
  task automatic t_faults;
    for (int k = 0; k < 3; k++) begin
      {scv, scg, oc} <= 3'h1 << k;
      wait_period;
      host.read(32, 0, w);
      check(w, exp_word(tcu, die, 3'h1 << k), "fault word");
    end
    {scv, scg, oc} <= 3'h0;
    wait_period;
  endtask
  task automatic t_freeze;
    t_old = tcu;
    tcu <= 14'h0190;
    host.read(32, 8 * PH, w);
    check(w, exp_word(t_old, die, 3'h0), "frozen word");
    host.read(16, 0, w);
    check(w, exp_word(14'h0190, die, 3'h0) >> 16, "aborted read");
    tcu <= 14'h0064;
    wait_period;
    host.read(32, 0, w);
    check(w, exp_word(14'h0064, die, 3'h0), "word after abort");
  endtask
  // Clock at 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {scv, scg, oc} = 3'h0;
    tcu = 14'h0190;
    die = 12'h190;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_full;
    t_short;
    t_faults;
    t_freeze;
    final_report;
  end
endmodule // thermocouple_serial_readout_tb
